// ==== core/arp_defs.vh ====
// Overview of operation
// - Data bus enabled only while select and read low.
// - Chip select gates the external data clock.
// - Reset pin aborts conversion, no result produced.
// - Power-down finishes conversion, then blocks new starts.
// - Start falling edge holds sample, begins conversion.
// - Impulse mode, fast mode off: low start at acquisition end converts.
// - Reference buffer on while disable input low.
// - Result kept as 18-bit output register.
// - Mode 0 drives all 18 result bits.
// - 16-bit mode, address low: bits 17..2.
// - 16-bit mode, address high: bits 1..0, zeros.
// - 8-bit mode: pins 0..2 inputs, 3..9 floating.
// - 8-bit, both addresses low: bits 17..10.
// - 8-bit, address 0 then 1: bits 9..2.
// - 8-bit, first address high: bits 1..0.
// - Mode 3: serial port, pins 2..9 floating.
// - Busy high from start until result latched.
// - Format select picks straight binary or two's complement in modes 1 to 3; mode 0 passes the code unchanged.
`ifndef ARP_DEFS_VH
`define ARP_DEFS_VH

// ==========================================================================
// Widths and bus modes.
`define ARP_RES_W 18
`define ARP_FIFO_DEPTH 4
`define ARP_FIFO_AW 2
`define ARP_MODE_PAR18 2'b00
`define ARP_MODE_WORD16 2'b01
`define ARP_MODE_BYTE8 2'b10
`define ARP_MODE_SERIAL 2'b11

// ==========================================================================
// Output enable masks of the data pins per mode.
`define ARP_OE_PAR18 18'h3ffff
`define ARP_OE_WORD16 18'h3fffc
`define ARP_OE_BYTE8 18'h3fc00
`define ARP_OE_SERIAL 18'h3f400
`define ARP_RESULT_RST 18'h00000

// ==========================================================================
// Conversion sequencer states.
`define ARP_ST_ACQ 2'b00
`define ARP_ST_READY 2'b01
`define ARP_ST_CONV 2'b10
`define ARP_ST_PDN 2'b11

// ==========================================================================
// Timing.
`define ARP_CNT_W 9
`define ARP_ACQ_CYC 9'h032
`define ARP_CONV_CYC 9'h0c8

`endif

// ==== core/arp_sync.v ====
`timescale 1ns/100ps

// ==========================================================================
// Two flip-flop synchroniser for a group of pin inputs.
module arp_sync #(
    parameter W = 1
) (
    input wire sys_clk_i,
    input wire sys_rst_i,
    input wire clk_en_i,
    input wire [W-1:0] async_i,
    output reg [W-1:0] sync_o
);
    reg [W-1:0] meta_reg;

    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            meta_reg <= {W{1'b0}};
            sync_o <= {W{1'b0}};
        end else if (clk_en_i) begin
            meta_reg <= async_i;
            sync_o <= meta_reg;
        end
    end
endmodule

// ==== core/arp_fifo.v ====
`timescale 1ns/100ps

// ==========================================================================
// Result FIFO with valid and ready on both sides.
module arp_fifo #(
    parameter W = 18,
    parameter D = 4,
    parameter AW = 2
) (
    input wire sys_clk_i,
    input wire sys_rst_i,
    input wire clk_en_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [W-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [W-1:0] out_data_o
);
    reg [W-1:0] mem [0:D-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire push;
    wire pop;

    assign in_ready_o = (count_reg != D[AW:0]);
    assign out_valid_o = (count_reg != {(AW+1){1'b0}});
    assign out_data_o = mem[rd_ptr_reg];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always @(posedge sys_clk_i) begin
        if (clk_en_i && push) begin
            mem[wr_ptr_reg] <= in_data_i;
        end
    end

    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else if (clk_en_i) begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

// ==== core/arp_port_ctrl.v ====
`timescale 1ns/100ps
`include "arp_defs.vh"

// ==========================================================================
// Conversion control and result output port.
module arp_port_ctrl (
    input wire sys_clk_i,
    input wire sys_rst_i,
    input wire clk_en_i,
    input wire cs_n_i,
    input wire rd_n_i,
    input wire start_conversion_n_i,
    input wire conv_reset_i,
    input wire power_down_i,
    input wire ref_buffer_disable_i,
    input wire bus_mode_hi_i,
    input wire bus_mode_lo_i,
    input wire impulse_i,
    input wire fast_mode_i,
    input wire [17:0] adc_code_i,
    input wire [17:0] data_i,
    output reg [17:0] data_o,
    output reg [17:0] data_oe_o,
    output reg busy_o,
    output reg hold_o,
    output reg ref_buf_en_o,
    output reg power_save_o,
    output reg fifo_stall_o
);
    // ======================================================================
    // Pin synchronisers.
    wire [13:0] pin_async;
    wire [13:0] pin_sync;
    wire cs_n_s;
    wire rd_n_s;
    wire start_n_s;
    wire conv_rst_s;
    wire pd_s;
    wire ref_buffer_disable_s;
    wire [1:0] mode_s;
    wire impulse_s;
    wire fast_s;
    wire format_s;
    wire word_addr_s;
    wire byte_addr_hi_s;
    wire ext_clk_s;

    assign pin_async = {data_i[11], data_i[2], data_i[1], data_i[0], fast_mode_i,
        impulse_i, bus_mode_lo_i, bus_mode_hi_i, ref_buffer_disable_i, power_down_i,
        conv_reset_i, ~start_conversion_n_i, ~rd_n_i, ~cs_n_i};

    arp_sync #(
        .W(14)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i),
        .async_i(pin_async),
        .sync_o(pin_sync)
    );

    // Active-low pins pass inverted, so the cleared synchroniser reads as idle.
    assign cs_n_s = ~pin_sync[0];
    assign rd_n_s = ~pin_sync[1];
    assign start_n_s = ~pin_sync[2];
    assign conv_rst_s = pin_sync[3];
    assign pd_s = pin_sync[4];
    assign ref_buffer_disable_s = pin_sync[5];
    assign mode_s = {pin_sync[6], pin_sync[7]};
    assign impulse_s = pin_sync[8];
    assign fast_s = pin_sync[9];
    assign format_s = pin_sync[10];
    assign word_addr_s = pin_sync[11];
    assign byte_addr_hi_s = pin_sync[12];
    assign ext_clk_s = pin_sync[13];

    // ======================================================================
    // Result coding in modes 1 to 3: high selects straight binary, low two's complement; mode 0 passes the code unchanged.
    function [17:0] arp_format;
        input [17:0] code;
        input [1:0] mode;
        input fmt;
        begin
            if (mode != `ARP_MODE_PAR18 && !fmt) begin
                arp_format = {~code[17], code[16:0]};
            end else begin
                arp_format = code;
            end
        end
    endfunction

    // ======================================================================
    // Edge detection on synchronised pins.
    reg start_n_d_reg;
    reg read_en_d_reg;
    reg ext_clk_d_reg;
    wire read_en;
    wire start_fall;
    wire ext_clk_rise;

    assign read_en = !cs_n_s && !rd_n_s;
    assign start_fall = start_n_d_reg && !start_n_s;
    assign ext_clk_rise = !ext_clk_d_reg && ext_clk_s && !cs_n_s;

    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            start_n_d_reg <= 1'b1;
            read_en_d_reg <= 1'b0;
            ext_clk_d_reg <= 1'b0;
        end else if (clk_en_i) begin
            start_n_d_reg <= start_n_s;
            read_en_d_reg <= read_en;
            ext_clk_d_reg <= ext_clk_s;
        end
    end

    // ======================================================================
    // Conversion sequencer.
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [`ARP_CNT_W-1:0] cnt_reg;
    reg [`ARP_CNT_W-1:0] cnt_next;
    reg push_valid;
    wire push_ready;
    wire conv_done;

    assign conv_done = (cnt_reg == {`ARP_CNT_W{1'b0}});

    always @* begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        push_valid = 1'b0;
        if (cnt_reg != {`ARP_CNT_W{1'b0}}) begin
            cnt_next = cnt_reg - 1'b1;
        end
        case (state_reg)
            `ARP_ST_ACQ: begin
                if (pd_s) begin
                    state_next = `ARP_ST_PDN;
                end else if (conv_done) begin
                    if (impulse_s && !fast_s && !start_n_s) begin
                        state_next = `ARP_ST_CONV;
                        cnt_next = `ARP_CONV_CYC;
                    end else begin
                        state_next = `ARP_ST_READY;
                    end
                end
            end
            `ARP_ST_READY: begin
                if (pd_s) begin
                    state_next = `ARP_ST_PDN;
                end else if (start_fall) begin
                    state_next = `ARP_ST_CONV;
                    cnt_next = `ARP_CONV_CYC;
                end
            end
            `ARP_ST_CONV: begin
                if (conv_done) begin
                    push_valid = 1'b1;
                    if (push_ready) begin
                        state_next = pd_s ? `ARP_ST_PDN : `ARP_ST_ACQ;
                        cnt_next = `ARP_ACQ_CYC;
                    end
                end
            end
            `ARP_ST_PDN: begin
                if (!pd_s) begin
                    state_next = `ARP_ST_ACQ;
                    cnt_next = `ARP_ACQ_CYC;
                end
            end
            default: begin
                state_next = `ARP_ST_ACQ;
                cnt_next = `ARP_ACQ_CYC;
            end
        endcase
    end

    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state_reg <= `ARP_ST_ACQ;
            cnt_reg <= `ARP_ACQ_CYC;
            busy_o <= 1'b0;
            hold_o <= 1'b0;
            power_save_o <= 1'b0;
            ref_buf_en_o <= 1'b0;
            fifo_stall_o <= 1'b0;
        end else if (clk_en_i) begin
            if (conv_rst_s) begin
                state_reg <= `ARP_ST_ACQ;
                cnt_reg <= `ARP_ACQ_CYC;
                busy_o <= 1'b0;
                hold_o <= 1'b0;
            end else begin
                state_reg <= state_next;
                cnt_reg <= cnt_next;
                busy_o <= (state_next == `ARP_ST_CONV);
                hold_o <= (state_next == `ARP_ST_CONV);
            end
            power_save_o <= (state_next == `ARP_ST_PDN) && !conv_rst_s;
            ref_buf_en_o <= !ref_buffer_disable_s;
            fifo_stall_o <= push_valid && !push_ready && !conv_rst_s;
        end
    end

    // ======================================================================
    // Result FIFO and output register.
    wire pop_valid;
    wire [17:0] pop_data;
    wire pop_ready;
    reg [17:0] result_reg;

    assign pop_ready = !read_en && !read_en_d_reg;

    arp_fifo #(
        .W(`ARP_RES_W),
        .D(`ARP_FIFO_DEPTH),
        .AW(`ARP_FIFO_AW)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i),
        .in_valid_i(push_valid && !conv_rst_s),
        .in_ready_o(push_ready),
        .in_data_i(adc_code_i),
        .out_valid_o(pop_valid),
        .out_ready_i(pop_ready),
        .out_data_o(pop_data)
    );

    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            result_reg <= `ARP_RESULT_RST;
        end else if (clk_en_i && pop_valid && pop_ready) begin
            result_reg <= pop_data;
        end
    end

    // ======================================================================
    // Serial shifter, loaded at the start of a read.
    reg [17:0] shift_reg;

    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            shift_reg <= `ARP_RESULT_RST;
        end else if (clk_en_i) begin
            if (read_en && !read_en_d_reg) begin
                shift_reg <= arp_format(result_reg, mode_s, format_s);
            end else if (ext_clk_rise && read_en) begin
                shift_reg <= {shift_reg[16:0], 1'b0};
            end
        end
    end

    // ======================================================================
    // Data pin multiplexer.
    reg [17:0] pins_next;
    reg [17:0] oe_next;
    reg [17:0] fmt_res;

    always @* begin
        fmt_res = arp_format(result_reg, mode_s, format_s);
        pins_next = 18'h00000;
        oe_next = 18'h00000;
        case (mode_s)
            `ARP_MODE_PAR18: begin
                oe_next = `ARP_OE_PAR18;
                pins_next = fmt_res;
            end
            `ARP_MODE_WORD16: begin
                oe_next = `ARP_OE_WORD16;
                if (!word_addr_s) begin
                    pins_next[17:2] = fmt_res[17:2];
                end else begin
                    pins_next[3:2] = fmt_res[1:0];
                end
            end
            `ARP_MODE_BYTE8: begin
                oe_next = `ARP_OE_BYTE8;
                case ({word_addr_s, byte_addr_hi_s})
                    2'b00: begin
                        pins_next[17:10] = fmt_res[17:10];
                    end
                    2'b01: begin
                        pins_next[17:10] = fmt_res[9:2];
                    end
                    2'b10: begin
                        pins_next[11:10] = fmt_res[1:0];
                    end
                    default: begin
                        pins_next[17:16] = fmt_res[1:0];
                    end
                endcase
            end
            default: begin
                oe_next = `ARP_OE_SERIAL;
                pins_next[10] = shift_reg[17];
                pins_next[12] = read_en;
            end
        endcase
        if (!read_en) begin
            oe_next = 18'h00000;
        end
    end

    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            data_o <= 18'h00000;
            data_oe_o <= 18'h00000;
        end else if (clk_en_i) begin
            data_o <= pins_next;
            data_oe_o <= oe_next;
        end
    end
endmodule

// ==== bench/arp_port_ctrl_assertions.sv ====
`timescale 1ns/100ps
`include "arp_defs.vh"

// ==========================================================================
// Port checker of the conversion control and result port.
module arp_port_ctrl_chk (
    input wire sys_clk_i,
    input wire sys_rst_i,
    input wire cs_n_i,
    input wire rd_n_i,
    input wire start_conversion_n_i,
    input wire conv_reset_i,
    input wire power_down_i,
    input wire ref_buffer_disable_i,
    input wire [17:0] data_oe_o,
    input wire busy_o,
    input wire hold_o,
    input wire ref_buf_en_o,
    input wire power_save_o,
    input wire fifo_stall_o
);
    localparam int CONV = `ARP_CONV_CYC;
    logic [8:0] busy_cnt_reg;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    // ==========================================================================
    // Counts the cycles of the running conversion.
    always @(posedge sys_clk_i) begin
        busy_cnt_reg <= (sys_rst_i || !busy_o) ? 9'h000 : busy_cnt_reg + 9'h001;
    end

    // ==========================================================================
    // Properties.
    property p_oe_idle;
        (cs_n_i || rd_n_i) [*5] |-> data_oe_o == 18'h00000;
    endproperty
    a_oe_idle: assert property (p_oe_idle)
        else $error("data pins driven while not read");
    property p_oe_cause;
        data_oe_o != 18'h00000 |-> !$past(cs_n_i || rd_n_i, 3);
    endproperty
    a_oe_cause: assert property (p_oe_cause)
        else $error("data pins driven without select and read");
    property p_oe_mask;
        data_oe_o != 18'h00000 |-> data_oe_o inside {`ARP_OE_PAR18, `ARP_OE_WORD16,
            `ARP_OE_BYTE8, `ARP_OE_SERIAL};
    endproperty
    a_oe_mask: assert property (p_oe_mask)
        else $error("output enable pattern fits no bus mode");
    property p_hold;
        hold_o == busy_o;
    endproperty
    a_hold: assert property (p_hold)
        else $error("hold differs from busy");
    property p_start;
        $rose(busy_o) |-> $past(!start_conversion_n_i, 3);
    endproperty
    a_start: assert property (p_start)
        else $error("conversion began without a low start");
    property p_busy_len;
        $fell(busy_o) |-> busy_cnt_reg >= CONV || $past(conv_reset_i, 3) ||
            $past(conv_reset_i, 4) || $past(conv_reset_i, 5);
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy fell before the conversion time");
    property p_abort;
        conv_reset_i [*5] |-> !busy_o;
    endproperty
    a_abort: assert property (p_abort)
        else $error("conversion kept running under reset");
    property p_pd_block;
        power_save_o && !busy_o |=> !busy_o;
    endproperty
    a_pd_block: assert property (p_pd_block)
        else $error("conversion began in power save");
    property p_pd_enter;
        (power_down_i && !busy_o) [*6] |-> power_save_o;
    endproperty
    a_pd_enter: assert property (p_pd_enter)
        else $error("power save not entered");
    property p_buf_on;
        (!ref_buffer_disable_i) [*5] |-> ref_buf_en_o;
    endproperty
    a_buf_on: assert property (p_buf_on)
        else $error("reference buffer off while enabled");
    property p_buf_off;
        ref_buffer_disable_i [*5] |-> !ref_buf_en_o;
    endproperty
    a_buf_off: assert property (p_buf_off)
        else $error("reference buffer on while disabled");
    property p_stall;
        fifo_stall_o |-> busy_o;
    endproperty
    a_stall: assert property (p_stall)
        else $error("busy low while a result waits");
    c_conv: cover property ($rose(busy_o));
    c_stall: cover property ($rose(fifo_stall_o));
    c_pd: cover property ($rose(power_save_o));
endmodule

// ==== bench/arp_host_model.sv ====
`timescale 1ns/100ps

// ==========================================================================
// Host that reads results over the shared data pins.
module arp_host_model (
    input wire sys_clk_i,
    input wire [2:0] pins_i,
    input wire [17:0] pin_out_i,
    input wire [17:0] pin_oe_i,
    output logic cs_n_o,
    output logic rd_n_o,
    output wire [17:0] pin_in_o,
    output logic done_o,
    output logic [35:0] seen_o
);
    initial begin
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        done_o = 1'b0;
        seen_o = 36'h0;
    end

    // Undriven pins 3..17 show the inverse of the last level, pins 0..2 the pins_i levels, never a kept value.
    assign pin_in_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & {~pin_out_i[17:3], pins_i});

    // Holds select and read low for hold_cyc cycles, then samples the bus.
    task automatic read(input int hold_cyc);
        @(negedge sys_clk_i);
        cs_n_o = 1'b0;
        rd_n_o = 1'b0;
        repeat (hold_cyc) @(negedge sys_clk_i);
        seen_o = {pin_oe_i, pin_out_i};
        done_o = 1'b1;
        @(negedge sys_clk_i);
        done_o = 1'b0;
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        repeat (5) @(negedge sys_clk_i);
    endtask

    task automatic park(input logic v);
        @(negedge sys_clk_i);
        cs_n_o = v;
        rd_n_o = v;
    endtask
endmodule

// ==== bench/test_adc_result_port_control.sv ====
`timescale 1ns/100ps
`include "arp_defs.vh"

module test_adc_result_port_control;
    localparam logic [31:0] RD_TBL = 32'hcb9a8540;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic start_conversion_n_i = 1'b1;
    logic conv_reset_i = 1'b0;
    logic power_down_i = 1'b0;
    logic ref_buffer_disable_i = 1'b0;
    logic bus_mode_hi_i = 1'b0;
    logic bus_mode_lo_i = 1'b0;
    logic impulse_i = 1'b0;
    logic fast_mode_i = 1'b0;
    logic [17:0] adc_code_i = 18'h00000;
    logic [17:0] code = 18'h00000;
    logic [2:0] pins = 3'b001;
    logic [53:0] exp_q[$];
    logic [53:0] e;
    logic [35:0] seen_m;
    int errors = 0;
    int total_checks = 0;
    wire cs_n_i, rd_n_i, busy_o, hold_o, ref_buf_en_o, power_save_o, fifo_stall_o, done;
    wire [17:0] data_i, data_o, data_oe_o;
    wire [35:0] host_seen;

    always #2.5 sys_clk_i = ~sys_clk_i;

    arp_port_ctrl dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1),
        .cs_n_i(cs_n_i), .rd_n_i(rd_n_i), .start_conversion_n_i(start_conversion_n_i),
        .conv_reset_i(conv_reset_i), .power_down_i(power_down_i),
        .ref_buffer_disable_i(ref_buffer_disable_i), .bus_mode_hi_i(bus_mode_hi_i),
        .bus_mode_lo_i(bus_mode_lo_i), .impulse_i(impulse_i), .fast_mode_i(fast_mode_i),
        .adc_code_i(adc_code_i), .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o),
        .busy_o(busy_o), .hold_o(hold_o), .ref_buf_en_o(ref_buf_en_o),
        .power_save_o(power_save_o), .fifo_stall_o(fifo_stall_o));

    arp_host_model u_host (.sys_clk_i(sys_clk_i), .pins_i(pins), .pin_out_i(data_o),
        .pin_oe_i(data_oe_o), .cs_n_o(cs_n_i), .rd_n_o(rd_n_i), .pin_in_o(data_i),
        .done_o(done), .seen_o(host_seen));

    // ==========================================================================
    // Checking and reporting.
    task automatic check(input string name, input logic [53:0] seen, input logic [53:0] expv);
        total_checks++;
        if (seen !== expv) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, expv, seen);
        end
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Returns output enables, compare mask and pin levels of one read.
    function automatic logic [53:0] expect_rd(logic [1:0] m, logic [2:0] p, logic [17:0] c);
        logic [17:0] r;
        r = (m != 2'b00 && !p[0]) ? c ^ 18'h20000 : c;
        case (m)
            2'b00: return {`ARP_OE_PAR18, `ARP_OE_PAR18, r};
            2'b01: return {`ARP_OE_WORD16, `ARP_OE_WORD16,
                p[1] ? {14'h0000, r[1:0], 2'b00} : {r[17:2], 2'b00}};
            2'b10: case ({p[1], p[2]})
                2'b00: return {`ARP_OE_BYTE8, `ARP_OE_BYTE8, r[17:10], 10'h000};
                2'b01: return {`ARP_OE_BYTE8, `ARP_OE_BYTE8, r[9:2], 10'h000};
                2'b10: return {`ARP_OE_BYTE8, `ARP_OE_BYTE8, 6'h00, r[1:0], 10'h000};
                default: return {`ARP_OE_BYTE8, `ARP_OE_BYTE8, r[1:0], 16'h0000};
            endcase
            default: return {`ARP_OE_SERIAL, `ARP_OE_SERIAL, 5'h00, 1'b1, 1'b0, r[17], 10'h000};
        endcase
    endfunction

    always @(posedge sys_clk_i) begin
        if (done === 1'b1) begin
            e = exp_q.pop_front();
            seen_m = {host_seen[35:18], host_seen[17:0] & e[35:18]};
            check("read", seen_m, {e[53:36], e[17:0]});
        end
    end

    // ==========================================================================
    // Drivers.
    task automatic rd(input logic [1:0] m, input logic [2:0] p);
        @(negedge sys_clk_i);
        {bus_mode_hi_i, bus_mode_lo_i} = m;
        pins = p;
        repeat (4) @(negedge sys_clk_i);
        exp_q.push_back(expect_rd(m, p, code));
        u_host.read(4 + $urandom % 4);
    endtask

    task automatic wait_busy(input logic v, input int lim);
        int n;
        n = 0;
        while (busy_o !== v && n < lim) begin
            @(negedge sys_clk_i);
            n++;
        end
        check("busy", busy_o, v);
    endtask

    task automatic kick(input logic [17:0] c, input logic rel);
        @(negedge sys_clk_i);
        adc_code_i = c;
        start_conversion_n_i = 1'b0;
        wait_busy(1'b1, 10);
        start_conversion_n_i = rel;
    endtask

    task automatic conv(input logic [17:0] c);
        kick(c, 1'b1);
        wait_busy(1'b0, 300);
        repeat (60) @(negedge sys_clk_i);
    endtask

    // ==========================================================================
    // Scenarios.
    initial begin
        void'($urandom(32'hc108));
        repeat (2) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        repeat (6) @(negedge sys_clk_i);
        check("ref_buf_en", ref_buf_en_o, 1'b1);
        ref_buffer_disable_i = 1'b1;
        repeat (6) @(negedge sys_clk_i);
        check("ref_buf_en", ref_buf_en_o, 1'b0);
        ref_buffer_disable_i = 1'b0;
        repeat (60) @(negedge sys_clk_i);
        for (int i = 0; i < 3; i++) begin
            code = 18'($urandom);
            conv(code);
            for (int k = 0; k < 8; k++) begin
                rd(RD_TBL[4*k+3 -: 2], {RD_TBL[4*k+1 -: 2], i[0]});
            end
        end
        kick(~code, 1'b1);
        repeat (20) @(negedge sys_clk_i);
        conv_reset_i = 1'b1;
        repeat (6) @(negedge sys_clk_i);
        check("busy", busy_o, 1'b0);
        conv_reset_i = 1'b0;
        repeat (300) @(negedge sys_clk_i);
        rd(2'b00, 3'b001);
        code = 18'($urandom);
        kick(code, 1'b1);
        power_down_i = 1'b1;
        wait_busy(1'b0, 300);
        repeat (6) @(negedge sys_clk_i);
        check("power_save", power_save_o, 1'b1);
        start_conversion_n_i = 1'b0;
        repeat (20) @(negedge sys_clk_i);
        check("busy", busy_o, 1'b0);
        start_conversion_n_i = 1'b1;
        power_down_i = 1'b0;
        repeat (60) @(negedge sys_clk_i);
        rd(2'b00, 3'b001);
        impulse_i = 1'b1;
        kick(18'h3ffff, 1'b0);
        wait_busy(1'b0, 300);
        wait_busy(1'b1, 80);
        start_conversion_n_i = 1'b1;
        impulse_i = 1'b0;
        wait_busy(1'b0, 300);
        repeat (60) @(negedge sys_clk_i);
        impulse_i = 1'b1;
        fast_mode_i = 1'b1;
        kick(18'h3ffff, 1'b0);
        wait_busy(1'b0, 300);
        repeat (80) @(negedge sys_clk_i);
        check("busy", busy_o, 1'b0);
        start_conversion_n_i = 1'b1;
        impulse_i = 1'b0;
        fast_mode_i = 1'b0;
        repeat (60) @(negedge sys_clk_i);
        u_host.park(1'b0);
        for (int j = 0; j < 4; j++) begin
            conv(18'($urandom));
        end
        code = 18'($urandom);
        kick(code, 1'b1);
        repeat (260) @(negedge sys_clk_i);
        check("fifo_stall", fifo_stall_o, 1'b1);
        check("busy", busy_o, 1'b1);
        u_host.park(1'b1);
        wait_busy(1'b0, 50);
        repeat (60) @(negedge sys_clk_i);
        rd(2'b00, 3'b001);
        repeat (10) @(negedge sys_clk_i);
        final_report();
    end

    initial begin
        #200000;
        errors++;
        final_report();
    end
endmodule

bind arp_port_ctrl arp_port_ctrl_chk u_chk (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .cs_n_i(cs_n_i), .rd_n_i(rd_n_i), .start_conversion_n_i(start_conversion_n_i),
    .conv_reset_i(conv_reset_i), .power_down_i(power_down_i),
    .ref_buffer_disable_i(ref_buffer_disable_i), .data_oe_o(data_oe_o), .busy_o(busy_o),
    .hold_o(hold_o), .ref_buf_en_o(ref_buf_en_o), .power_save_o(power_save_o),
    .fifo_stall_o(fifo_stall_o));
